/* gpt_defines.svh */
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// Register byte offsets within one timer instance
`define GPT_OFS_RELOAD 12'h000
`define GPT_OFS_VALUE 12'h004
`define GPT_OFS_CONTROL 12'h008
`define GPT_OFS_CLEAR 12'h00c
`define GPT_OFS_CAPTURE 12'h010
`define GPT_OFS_STATUS 12'h01c
`define GPT_INST_STRIDE 12'h400
`define GPT_INST_BIT 10

// Control register fields
`define GPT_CON_PRE_LSB 0
`define GPT_CON_PRE_MSB 1
`define GPT_CON_UP 2
`define GPT_CON_PERIODIC 3
`define GPT_CON_EN 4
`define GPT_CON_SRC_LSB 5
`define GPT_CON_SRC_MSB 6
`define GPT_CON_RLD 7
`define GPT_CON_EVT_LSB 8
`define GPT_CON_EVT_MSB 11
`define GPT_CON_EVTEN 12
`define GPT_CON_RST 16'h000a
`define GPT_CON_WMASK 16'h1fff

// Clear register and status register bits
`define GPT_CLR_TMO 0
`define GPT_CLR_CAP 1
`define GPT_STA_TMO 0
`define GPT_STA_CAP 1
`define GPT_STA_CON_BUSY 6
`define GPT_STA_CLR_BUSY 7

// Counter limits and prescaler terminal counts (divide minus one)
`define GPT_FULL_SCALE 16'hffff
`define GPT_ZERO_SCALE 16'h0000
`define GPT_LIM_DIV1 15'h0000
`define GPT_LIM_DIV4 15'h0003
`define GPT_LIM_DIV16 15'h000f
`define GPT_LIM_DIV256 15'h00ff
`define GPT_LIM_DIV32768 15'h7fff

`endif

/* gpt_pkg.sv */
package gpt_pkg;

   typedef enum logic [1:0] {
      GPT_SRC_UNDIVIDED,
      GPT_SRC_PERIPH,
      GPT_SRC_LF_OSC,
      GPT_SRC_LF_CRYSTAL
   } gpt_src_t;

   typedef enum logic [1:0] {
      GPT_PRE_DIV1,
      GPT_PRE_DIV16,
      GPT_PRE_DIV256,
      GPT_PRE_DIV32768
   } gpt_pre_t;

endpackage

/* gpt_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

module gpt_prescaler #(
   parameter int CNT_W = 15
) (
   input wire logic clk_i,
   input wire logic rst_i,
   gpt_tick_if.presc tk
);
   import gpt_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] lim;

   always_comb begin
      unique case (tk.pre)
         GPT_PRE_DIV1: lim = tk.fast ? CNT_W'(`GPT_LIM_DIV4) : CNT_W'(`GPT_LIM_DIV1);
         GPT_PRE_DIV16: lim = CNT_W'(`GPT_LIM_DIV16);
         GPT_PRE_DIV256: lim = CNT_W'(`GPT_LIM_DIV256);
         GPT_PRE_DIV32768: lim = CNT_W'(`GPT_LIM_DIV32768);
      endcase
      cnt_d = cnt_q;
      if (!tk.run) begin
         cnt_d = '0;
      end else if (tk.src_tick) begin
         // Compare with >= so a lowered ratio cannot strand the count
         cnt_d = (cnt_q >= lim) ? '0 : cnt_q + CNT_W'(1);
      end
   end

   assign tk.tick = tk.run && tk.src_tick && (cnt_q >= lim);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

`default_nettype wire

/* gpt_tick_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface gpt_tick_if;
   import gpt_pkg::*;
   logic src_tick;
   gpt_pre_t pre;
   logic fast;
   logic run;
   logic tick;

   modport ctl (output src_tick, output pre, output fast, output run, input tick);
   modport presc (input src_tick, input pre, input fast, input run, output tick);
endinterface

`default_nettype wire

/* gpt_timers.sv */
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

module gpt_timers (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pclk_en_i,
   input wire logic low_freq_internal_osc_en_i,
   input wire logic low_freq_crystal_en_i,
   input wire logic hibernate_i,
   input wire logic [14:0] t0_evt_i,
   input wire logic [14:0] t1_evt_i,
   output logic [1:0] timeout_irq_o
);
   import gpt_pkg::*;

   // Source enable pulses stand in for the slower clocks
   function automatic logic source_tick(input gpt_src_t src, input logic pclk_en,
                                        input logic low_freq_internal_osc_en, input logic low_freq_crystal_en);
      logic t;
      unique case (src)
         GPT_SRC_UNDIVIDED: t = 1'b1;
         GPT_SRC_PERIPH: t = pclk_en;
         GPT_SRC_LF_OSC: t = low_freq_internal_osc_en;
         GPT_SRC_LF_CRYSTAL: t = low_freq_crystal_en;
      endcase
      return t;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wdat,
                                           input logic [1:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wdat[15:8];
      end
      return r;
   endfunction

   logic ack_q;
   logic ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic bus_wr;
   logic inst_sel;
   logic [11:0] ofs;
   logic [15:0] rd_word [2];
   logic [1:0] tmo_ev;
   logic [15:0] evt_vec [2];

   assign inst_sel = wb_adr_i[`GPT_INST_BIT];
   assign ofs = wb_adr_i & ~`GPT_INST_STRIDE;
   // Writes land only on the edge that also carries ack
   assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

   // first timer source map, code 11 and 15 unused
   assign evt_vec[0] = {1'b0, t0_evt_i[14:13], tmo_ev[1], 1'b0, t0_evt_i[10:0]};
   // second timer source map, code 5 and 15 unused
   assign evt_vec[1] = {1'b0, t1_evt_i[14:6], 1'b0, t1_evt_i[4:1], tmo_ev[0]};

   always_comb begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = ack_d ? {16'h0000, rd_word[inst_sel]} : 32'h0000_0000;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   for (genvar g = 0; g < 2; g++) begin : g_tmr
      logic [15:0] reload_value_q;
      logic [15:0] reload_value_d;
      logic [15:0] timer_control_q;
      logic [15:0] timer_control_d;
      logic [15:0] active_control_q;
      logic [15:0] active_control_d;
      logic [15:0] counter_value_q;
      logic [15:0] counter_value_d;
      logic [15:0] capture_value_q;
      logic [15:0] capture_value_d;
      logic tmo_flag_q;
      logic tmo_flag_d;
      logic cap_pend_q;
      logic cap_pend_d;
      logic con_busy_q;
      logic con_busy_d;
      logic [2:0] clr_pend_q;
      logic [2:0] clr_pend_d;
      logic hit;
      logic shadow_tick;
      logic con_apply;
      logic clr_apply;
      logic run_en;
      logic counting_up;
      logic periodic;
      logic starting;
      logic cap_event;
      logic cap_free;
      logic tmo_pulse;
      logic [15:0] term;
      logic [15:0] wrap_val;
      gpt_src_t act_src;

      gpt_tick_if tk ();

      gpt_prescaler #(
         .CNT_W(15)
      ) u_presc (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tk(tk.presc)
      );

      // source chosen by the active control bits
      assign act_src = gpt_src_t'(active_control_q[`GPT_CON_SRC_MSB:`GPT_CON_SRC_LSB]);
      assign run_en = active_control_q[`GPT_CON_EN] && !hibernate_i;
      assign tk.src_tick = !hibernate_i
         && source_tick(act_src, pclk_en_i, low_freq_internal_osc_en_i, low_freq_crystal_en_i);
      assign tk.pre = gpt_pre_t'(active_control_q[`GPT_CON_PRE_MSB:`GPT_CON_PRE_LSB]);
      assign tk.fast = (act_src == GPT_SRC_UNDIVIDED) || (act_src == GPT_SRC_PERIPH);
      assign tk.run = run_en;

      assign hit = inst_sel == 1'(g);
      // Crossing modelled as waiting for an edge of the target source
      assign shadow_tick = !hibernate_i && source_tick(
         gpt_src_t'(timer_control_q[`GPT_CON_SRC_MSB:`GPT_CON_SRC_LSB]),
         pclk_en_i, low_freq_internal_osc_en_i, low_freq_crystal_en_i);

      always_comb begin
         reload_value_d = reload_value_q;
         timer_control_d = timer_control_q;
         active_control_d = active_control_q;
         counter_value_d = counter_value_q;
         capture_value_d = capture_value_q;
         tmo_flag_d = tmo_flag_q;
         cap_pend_d = cap_pend_q;
         con_busy_d = con_busy_q;
         clr_pend_d = clr_pend_q;
         tmo_pulse = 1'b0;
         counting_up = active_control_q[`GPT_CON_UP];
         periodic = active_control_q[`GPT_CON_PERIODIC];
         term = counting_up ? `GPT_FULL_SCALE : `GPT_ZERO_SCALE;
         wrap_val = counting_up ? `GPT_ZERO_SCALE : `GPT_FULL_SCALE;

         if (bus_wr && hit && ofs == `GPT_OFS_RELOAD) begin
            reload_value_d = merge16(reload_value_q, wb_dat_i[15:0], wb_sel_i[1:0]);
         end

         // control write busy until taken on the timer side
         con_apply = con_busy_q && shadow_tick;
         if (con_apply) begin
            active_control_d = timer_control_q;
            con_busy_d = 1'b0;
         end
         if (bus_wr && hit && ofs == `GPT_OFS_CONTROL) begin
            timer_control_d = merge16(timer_control_q, wb_dat_i[15:0], wb_sel_i[1:0])
               & `GPT_CON_WMASK;
            con_busy_d = 1'b1;
         end

         // clear write busy until taken on the timer side
         clr_apply = (|clr_pend_q) && shadow_tick;
         if (clr_apply) begin
            clr_pend_d = 3'b000;
         end
         if (bus_wr && hit && ofs == `GPT_OFS_CLEAR) begin
            clr_pend_d[`GPT_CLR_TMO] = clr_pend_d[`GPT_CLR_TMO]
               || (wb_sel_i[0] && wb_dat_i[`GPT_CLR_TMO]);
            clr_pend_d[`GPT_CLR_CAP] = clr_pend_d[`GPT_CLR_CAP]
               || (wb_sel_i[0] && wb_dat_i[`GPT_CLR_CAP]);
            clr_pend_d[2] = 1'b1;
         end

         starting = con_apply && timer_control_q[`GPT_CON_EN]
            && !active_control_q[`GPT_CON_EN];
         if (starting) begin
            // start from zero or full scale, or from the reload value when periodic
            counter_value_d = timer_control_q[`GPT_CON_UP] ? `GPT_ZERO_SCALE
                                                            : `GPT_FULL_SCALE;
            if (timer_control_q[`GPT_CON_PERIODIC]) begin
               counter_value_d = reload_value_q;
            end
         end else if (!active_control_q[`GPT_CON_EN]) begin
            counter_value_d = `GPT_ZERO_SCALE;
         end else if (clr_apply && clr_pend_q[2] && periodic
                      && active_control_q[`GPT_CON_RLD]) begin
            counter_value_d = reload_value_q;
         end else if (tk.tick) begin
            if (counter_value_q == term) begin
               counter_value_d = periodic ? reload_value_q : wrap_val;
            end else begin
               counter_value_d = counting_up ? counter_value_q + 16'h0001
                                             : counter_value_q - 16'h0001;
               tmo_pulse = counter_value_d == term;
            end
         end

         // timeout sticky, set wins over clear
         tmo_flag_d = tmo_pulse
            || (tmo_flag_q && !(clr_apply && clr_pend_q[`GPT_CLR_TMO]));

         cap_event = active_control_q[`GPT_CON_EVTEN]
            && evt_vec[g][active_control_q[`GPT_CON_EVT_MSB:`GPT_CON_EVT_LSB]];
         cap_free = !cap_pend_q || (clr_apply && clr_pend_q[`GPT_CLR_CAP]);
         if (cap_event && cap_free) begin
            capture_value_d = counter_value_q;
            cap_pend_d = 1'b1;
         end else if (clr_apply && clr_pend_q[`GPT_CLR_CAP]) begin
            cap_pend_d = 1'b0;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            reload_value_q <= 16'h0000;
            timer_control_q <= `GPT_CON_RST;
            active_control_q <= `GPT_CON_RST;
            counter_value_q <= 16'h0000;
            capture_value_q <= 16'h0000;
            tmo_flag_q <= 1'b0;
            cap_pend_q <= 1'b0;
            con_busy_q <= 1'b0;
            clr_pend_q <= 3'b000;
         end else begin
            reload_value_q <= reload_value_d;
            timer_control_q <= timer_control_d;
            active_control_q <= active_control_d;
            counter_value_q <= counter_value_d;
            capture_value_q <= capture_value_d;
            tmo_flag_q <= tmo_flag_d;
            cap_pend_q <= cap_pend_d;
            con_busy_q <= con_busy_d;
            clr_pend_q <= clr_pend_d;
         end
      end

      always_comb begin
         rd_word[g] = 16'h0000;
         unique case (ofs)
            `GPT_OFS_RELOAD: rd_word[g] = reload_value_q;
            // value held in the bus clock domain
            `GPT_OFS_VALUE: rd_word[g] = counter_value_q;
            `GPT_OFS_CONTROL: rd_word[g] = timer_control_q;
            `GPT_OFS_CAPTURE: rd_word[g] = capture_value_q;
            `GPT_OFS_STATUS: begin
               rd_word[g][`GPT_STA_TMO] = tmo_flag_q;
               rd_word[g][`GPT_STA_CAP] = cap_pend_q;
               rd_word[g][`GPT_STA_CON_BUSY] = con_busy_q;
               rd_word[g][`GPT_STA_CLR_BUSY] = |clr_pend_q;
            end
            // Clear register and holes read zero
            default: rd_word[g] = 16'h0000;
         endcase
      end

      assign tmo_ev[g] = tmo_pulse;
      assign timeout_irq_o[g] = tmo_flag_q;
   end

endmodule

`default_nettype wire

/* gpt_timers_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module gpt_timers_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic hibernate_i,
   input wire logic [1:0] timeout_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd_ack;
      wb_ack_o && !wb_we_i;
   endsequence
   // Two cycles asleep so no tick already in flight can land
   sequence s_asleep;
      hibernate_i [*2];
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_clear_reads_zero: assert property (s_rd_ack ##0 wb_adr_i[9:0] == 10'h00c
      |-> wb_dat_o == 32'h0)
      else $error("clear register read not zero");
   a_status_resv_zero: assert property (s_rd_ack ##0 wb_adr_i[9:0] == 10'h01c
      |-> wb_dat_o[15:8] == 8'h0 && wb_dat_o[5:2] == 4'h0)
      else $error("status reserved bits set");
   a_irq_frozen: assert property (s_asleep |=> timeout_irq_o == $past(timeout_irq_o))
      else $error("timeout flag moved in hibernate");
endmodule
bind gpt_timers gpt_timers_sva gpt_timers_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hibernate_i(hibernate_i),
   .timeout_irq_o(timeout_irq_o));
`default_nettype wire

/* gpt_timers_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"
module gpt_timers_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hib = 1'b0;
   logic pclk = 1'b0, lfo = 1'b0, lfx = 1'b0, ack;
   logic [11:0] adr = 12'h0, b = 12'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, e, cnt = 32'h0;
   logic [14:0] e0 = 15'h0, e1 = 15'h0;
   logic [1:0] irq;
   logic [15:0] r, v, ld, cap, ctl;
   logic [31:0] expq[$];
   int n_errors = 0, checks_done = 0, seed = 32'h24d3d11a, n;
   logic [11:0] ofs[7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h01c, 12'h014};
   logic [15:0] rstv[7] = '{16'h0, 16'h0, 16'h000a, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [15:0] ctla[7] = '{16'h0004, 16'h0005, 16'h0006, 16'h0024, 16'h0044, 16'h0065, 16'h0007};
   int wta[7] = '{400, 400, 1024, 400, 400, 1600, 33000};
   int expa[7] = '{100, 25, 4, 50, 50, 6, 1};
   gpt_timers gpt_timers_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pclk_en_i(pclk), .low_freq_internal_osc_en_i(lfo), .low_freq_crystal_en_i(lfx),
      .hibernate_i(hib), .t0_evt_i(e0), .t1_evt_i(e1), .timeout_irq_o(irq));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Slow sources as pulse trains: every 2, 8 and 16 cycles
   always @(posedge clk_i) begin
      cnt <= cnt + 32'h1;
      pclk <= cnt[0];
      lfo <= (cnt[2:0] == 3'h7);
      lfx <= (cnt[3:0] == 4'hf);
   end
   task automatic complete_run();
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t read got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // Results taken at the rising edge that samples ack
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
         e = expq.pop_front();
         cmp(rdat[15:0] & e[31:16], e[15:0] & e[31:16]);
      end
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic [15:0] m);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0, d};
      sel <= 4'h3;
      if (!w) expq.push_back({m, d});
      // No cycle count assumed; only the watchdog ends this wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      bus(1'b1, a, d, 16'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] d);
      bus(1'b0, a, d, 16'hffff);
   endtask
   task automatic rdm(input logic [11:0] a, input logic [15:0] d, input logic [15:0] m);
      bus(1'b0, a, d, m);
   endtask
   // Count may step between reads; a third read settles it
   task automatic rd_val();
      logic [15:0] first;
      rdm(b + `GPT_OFS_VALUE, 16'h0, 16'h0);
      first = r;
      rdm(b + `GPT_OFS_VALUE, 16'h0, 16'h0);
      if (r !== first) begin
         rdm(b + `GPT_OFS_VALUE, 16'h0, 16'h0);
      end
   endtask
   task automatic sync();
      int k;
      k = 0;
      do begin
         rdm(b + `GPT_OFS_STATUS, 16'h0, 16'h0);
         k++;
      end while (r[7:6] !== 2'b00 && k < 40);
      chk(k < 40, "sync flags stuck");
   endtask
   task automatic pulse(input int t, input logic [14:0] p);
      @(posedge clk_i);
      if (t == 0) e0 <= p;
      else e1 <= p;
      @(posedge clk_i);
      e0 <= 15'h0;
      e1 <= 15'h0;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      n_errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         b = (i == 1) ? 12'h400 : 12'h000;
         foreach (ofs[j]) rd(b + ofs[j], rstv[j]);
         wr(b + 12'h014, 16'hffff);
         wr(b + `GPT_OFS_VALUE, 16'h1234);
         rd(b + 12'h014, 16'h0);
         rd(b + `GPT_OFS_VALUE, 16'h0);
         ld = 16'h20 + 16'($random(seed) & 'hf);
         wr(b + `GPT_OFS_RELOAD, ld);
         wr(b + `GPT_OFS_CONTROL, 16'h0008);
         sync();
         wr(b + `GPT_OFS_CONTROL, 16'h0018);
         n = 0;
         while (irq[i] !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
         end
         chk(n >= ld * 4 - 4 && n <= ld * 4 + 8, "periodic timeout time");
         rdm(b + `GPT_OFS_STATUS, 16'h1, 16'h1);
         repeat (30) @(posedge clk_i);
         chk(irq[i] === 1'b1, "timeout flag not held");
         wr(b + `GPT_OFS_CLEAR, 16'h1);
         sync();
         chk(irq[i] === 1'b0, "timeout flag not cleared");
         rd(b + `GPT_OFS_CLEAR, 16'h0);
         wr(b + `GPT_OFS_CONTROL, 16'h0008);
         sync();
      end
      b = 12'h000;
      foreach (ctla[j]) begin
         wr(`GPT_OFS_CONTROL, ctla[j]);
         sync();
         wr(`GPT_OFS_CONTROL, ctla[j] | 16'h0010);
         sync();
         repeat (wta[j]) @(posedge clk_i);
         rd_val();
         chk(int'(r) + 3 >= expa[j] && int'(r) <= expa[j] + 3, "prescaled count");
         wr(`GPT_OFS_CONTROL, ctla[j]);
         sync();
         rd(`GPT_OFS_VALUE, 16'h0);
      end
      wr(`GPT_OFS_RELOAD, 16'h2000);
      wr(`GPT_OFS_CONTROL, 16'h0088);
      sync();
      wr(`GPT_OFS_CONTROL, 16'h0098);
      sync();
      repeat (100) @(posedge clk_i);
      wr(`GPT_OFS_RELOAD, 16'h0100);
      wr(`GPT_OFS_CLEAR, 16'h0000);
      sync();
      rdm(`GPT_OFS_VALUE, 16'h0, 16'h0);
      chk(r <= 16'h0100 && r >= 16'h00f0, "reload on clear write");
      wr(`GPT_OFS_CONTROL, 16'h0000);
      sync();
      wr(`GPT_OFS_CONTROL, 16'h0010);
      sync();
      rdm(`GPT_OFS_VALUE, 16'h0, 16'h0);
      chk(r >= 16'hfff0, "down count start");
      hib <= 1'b1;
      repeat (4) @(posedge clk_i);
      rdm(`GPT_OFS_VALUE, 16'h0, 16'h0);
      v = r;
      repeat (40) @(posedge clk_i);
      rd(`GPT_OFS_VALUE, v);
      hib <= 1'b0;
      repeat (20) @(posedge clk_i);
      rdm(`GPT_OFS_VALUE, 16'h0, 16'h0);
      chk(r < v, "counting not resumed");
      wr(`GPT_OFS_CONTROL, 16'h0000);
      sync();
      for (int t = 0; t < 2; t++) begin
         b = (t == 1) ? 12'h400 : 12'h000;
         for (int c = 0; c < 15; c++) begin
            if (t == 0 ? (c == 11 || c == 12) : (c == 0 || c == 5)) continue;
            ctl = 16'h1004 | 16'(c << 8);
            wr(b + `GPT_OFS_CONTROL, ctl);
            sync();
            wr(b + `GPT_OFS_CONTROL, ctl | 16'h0010);
            sync();
            repeat (20) @(posedge clk_i);
            pulse(t, ~(15'h1 << c));
            rdm(b + `GPT_OFS_STATUS, 16'h0, 16'h2);
            pulse(t, 15'h1 << c);
            rdm(b + `GPT_OFS_STATUS, 16'h2, 16'h2);
            rdm(b + `GPT_OFS_CAPTURE, 16'h0, 16'h0);
            cap = r;
            rdm(b + `GPT_OFS_VALUE, 16'h0, 16'h0);
            chk(cap > 16'h0 && cap < r, "capture value");
            pulse(t, 15'h1 << c);
            rd(b + `GPT_OFS_CAPTURE, cap);
            wr(b + `GPT_OFS_CLEAR, 16'h2);
            sync();
            rdm(b + `GPT_OFS_STATUS, 16'h0, 16'h2);
            wr(b + `GPT_OFS_CONTROL, ctl);
            sync();
         end
      end
      complete_run();
   end
endmodule
`default_nettype wire
